// File: gtu_defines.svh
// Register offsets, field positions and reset values of the general timer unit control block.
`ifndef GTU_DEFINES_SVH
`define GTU_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define GTU_CFG_OFS        12'h000
`define GTU_CTL_OFS        12'h00c
`define GTU_IMR_OFS        12'h018
`define GTU_RIS_OFS        12'h01c
`define GTU_MIS_OFS        12'h020
`define GTU_ICR_OFS        12'h024

// ==========================================================================
// Control register fields
`define GTU_CTL_A_RUN      0
`define GTU_CTL_A_FREEZE   1
`define GTU_CTL_A_EDGE_LO  2
`define GTU_CTL_CLK_RUN    4
`define GTU_CTL_A_TRIG     5
`define GTU_CTL_A_INV      6
`define GTU_CTL_B_RUN      8
`define GTU_CTL_B_FREEZE   9
`define GTU_CTL_B_EDGE_LO  10
`define GTU_CTL_B_TRIG     13
`define GTU_CTL_B_INV      14
`define GTU_CTL_WMASK      32'h00006f7f

// ==========================================================================
// Interrupt bit positions, shared by mask, raw, masked and clear registers
`define GTU_IRQ_A_TIMEOUT  0
`define GTU_IRQ_A_MATCH    1
`define GTU_IRQ_A_CAPTURE  2
`define GTU_IRQ_CLOCK      3
`define GTU_IRQ_B_TIMEOUT  8
`define GTU_IRQ_B_MATCH    9
`define GTU_IRQ_B_CAPTURE  10
`define GTU_IRQ_WMASK      32'h0000070f

// ==========================================================================
// Reset values and configuration codes
`define GTU_CTL_RESET      32'h00000000
`define GTU_IMR_RESET      32'h00000000
`define GTU_RIS_RESET      32'h00000000
`define GTU_CFG_RESET      3'h0
`define GTU_CFG_RTC        3'h1

`endif

// File: gtu_pkg.sv
// Types shared by the general timer unit control block.
package gtu_pkg;

    // Capture edge selection codes.
    typedef enum logic [1:0]
    {
        GTU_EDGE_RISE     = 2'h0,
        GTU_EDGE_FALL     = 2'h1,
        GTU_EDGE_RESERVED = 2'h2,
        GTU_EDGE_BOTH     = 2'h3
    } gtu_edge_t;

    // Operating mode decoded from the global configuration.
    typedef enum logic [1:0]
    {
        GTU_MODE_T32,
        GTU_MODE_RTC,
        GTU_MODE_T16,
        GTU_MODE_BAD
    } gtu_mode_t;

endpackage

// File: gtu_ctrl.sv
// Control, trigger routing and interrupt status logic of the general timer unit.
// Operation
// - Bit 14 inverts channel B PWM output.
// - Bit 6 inverts channel A PWM output.
// - Bit 13 gates channel B output trigger.
// - Bit 5 gates channel A output trigger.
// - Channel triggers drive converter start inputs.
// - Bits 11:10 select channel B capture edge.
// - Bits 3:2 select channel A capture edge.
// - Bit 9 enables channel B debug stall.
// - Bit 1 enables channel A debug stall.
// - Bit 8 starts or stops channel B.
// - Bit 0 starts or stops channel A.
// - Bit 4 enables real-time clock counting.
// - Mask bit one enables its interrupt source.
// - Mask bits at 10,9,8,3,2,1,0 only.
// - Raw status sets regardless of mask.
// - Raw bit holds until write-one clear.
// - Raw bits share mask bit positions.
// - Masked status equals raw AND mask.
// - Configuration selects 32-bit, clock or 16-bit mode.
`timescale 1ns/1ns
`include "gtu_defines.svh"

module gtu_ctrl
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // AXI4-Lite slave.
    input  wire logic [11:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [11:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Events from the counter cores, one-cycle pulses.
    input  wire logic             a_timeout_evt,
    input  wire logic             a_match_evt,
    input  wire logic             a_capture_evt,
    input  wire logic             clock_evt,
    input  wire logic             b_timeout_evt,
    input  wire logic             b_match_evt,
    input  wire logic             b_capture_evt,
    // Raw PWM levels and trigger pulses from the counter cores.
    input  wire logic             a_pwm_raw,
    input  wire logic             b_pwm_raw,
    input  wire logic             a_trig_raw,
    input  wire logic             b_trig_raw,
    input  wire logic             debug_halt,
    // Steering toward the counter cores.
    output logic                  chan_a_count_en,
    output logic                  chan_b_count_en,
    output logic                  clock_count_en,
    output gtu_pkg::gtu_edge_t    chan_a_edge_select,
    output gtu_pkg::gtu_edge_t    chan_b_edge_select,
    output gtu_pkg::gtu_mode_t    unit_mode,
    output logic                  chan_a_pwm_out,
    output logic                  chan_b_pwm_out,
    output logic                  adc_trig_a,
    output logic                  adc_trig_b,
    output logic                  timer_irq
);
    import gtu_pkg::*;

    // ======================================================================
    // Register state
    logic [31:0] timer_control_r;
    logic [31:0] interrupt_mask_r;
    logic [31:0] raw_interrupt_status_r;
    logic [2:0]  global_configuration_r;
    logic [31:0] events;
    logic        wr_fire;
    logic        aw_held_r;
    logic        w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;

    // Byte-lane merge used by the control and mask registers and the clear write.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge = (old & ~m) | (nw & m);
    endfunction

    // Word index of a byte offset; the two low address bits never select a register.
    function automatic logic [9:0] word_index(input logic [11:0] ofs);
        word_index = ofs[11:2];
    endfunction

    // Decode of the configuration code into a mode.
    function automatic gtu_mode_t decode_mode(input logic [2:0] cfg);
        if (cfg[2])
            decode_mode = GTU_MODE_T16;
        else if (cfg == `GTU_CFG_RESET)
            decode_mode = GTU_MODE_T32;
        else if (cfg == `GTU_CFG_RTC)
            decode_mode = GTU_MODE_RTC;
        else
            decode_mode = GTU_MODE_BAD;
    endfunction

    // ======================================================================
    // Write channel: address and data taken in either order, one at a time.
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

    // Address capture; ready falls once an address is held.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r     <= 1'b0;
            awaddr_r      <= 12'h000;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_r <= 1'b0;
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
        end
    end

    // Data capture, mirror of the address side.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_r     <= 1'b0;
            wdata_r      <= 32'h00000000;
            wstrb_r      <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_r <= 1'b0;
            s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // Write response; unmapped or read-only offsets answer SLVERR.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            unique case (awaddr_r[11:2])
                word_index(`GTU_CFG_OFS), word_index(`GTU_CTL_OFS),
                word_index(`GTU_IMR_OFS), word_index(`GTU_ICR_OFS):
                    s_axi_bresp <= 2'h0;
                default:
                    s_axi_bresp <= 2'h2;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ======================================================================
    // Software-written registers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_control_r        <= `GTU_CTL_RESET;
            interrupt_mask_r       <= `GTU_IMR_RESET;
            global_configuration_r <= `GTU_CFG_RESET;
        end
        else if (wr_fire)
        begin
            // Reserved bits are kept at zero so software cannot disturb them.
            if (awaddr_r[11:2] == word_index(`GTU_CTL_OFS))
                timer_control_r <= merge(timer_control_r, wdata_r, wstrb_r, `GTU_CTL_WMASK);
            if (awaddr_r[11:2] == word_index(`GTU_IMR_OFS))
                interrupt_mask_r <= merge(interrupt_mask_r, wdata_r, wstrb_r,
                                          `GTU_IRQ_WMASK);
            if (awaddr_r[11:2] == word_index(`GTU_CFG_OFS) && wstrb_r[0])
                global_configuration_r <= wdata_r[2:0];
        end
    end

    // ======================================================================
    // Raw status: events latch regardless of mask, set beats a same-cycle clear.
    assign events = {21'h000000, b_capture_evt, b_match_evt, b_timeout_evt, 4'h0,
                     clock_evt, a_capture_evt, a_match_evt, a_timeout_evt};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            raw_interrupt_status_r <= `GTU_RIS_RESET;
        else if (wr_fire && awaddr_r[11:2] == word_index(`GTU_ICR_OFS))
            raw_interrupt_status_r <= ((raw_interrupt_status_r & ~merge(32'h0, wdata_r, wstrb_r,
                                        `GTU_IRQ_WMASK)) | events) & `GTU_IRQ_WMASK;
        else
            raw_interrupt_status_r <= (raw_interrupt_status_r | events)
                                      & `GTU_IRQ_WMASK;
    end

    // ======================================================================
    // Read channel: one read at a time, answer one cycle after the address.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            unique case (s_axi_araddr[11:2])
                word_index(`GTU_CFG_OFS): s_axi_rdata <= {29'h0, global_configuration_r};
                word_index(`GTU_CTL_OFS): s_axi_rdata <= timer_control_r;
                word_index(`GTU_IMR_OFS): s_axi_rdata <= interrupt_mask_r;
                word_index(`GTU_RIS_OFS): s_axi_rdata <= raw_interrupt_status_r;
                word_index(`GTU_MIS_OFS):
                    s_axi_rdata <= raw_interrupt_status_r & interrupt_mask_r;
                word_index(`GTU_ICR_OFS): s_axi_rdata <= 32'h00000000;
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else
            s_axi_arready <= 1'b1;
    end

    // ======================================================================
    // Steering outputs: enables are held off while a frozen channel sees a halt.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            chan_a_count_en    <= 1'b0;
            chan_b_count_en    <= 1'b0;
            clock_count_en     <= 1'b0;
            chan_a_edge_select <= GTU_EDGE_RISE;
            chan_b_edge_select <= GTU_EDGE_RISE;
            unit_mode          <= GTU_MODE_T32;
        end
        else
        begin
            chan_a_count_en <= timer_control_r[`GTU_CTL_A_RUN]
                               && !(timer_control_r[`GTU_CTL_A_FREEZE]
                                    && debug_halt);
            chan_b_count_en <= timer_control_r[`GTU_CTL_B_RUN]
                               && !(timer_control_r[`GTU_CTL_B_FREEZE]
                                    && debug_halt);
            // Clock counting also rides on channel A's freeze, as it uses that counter.
            clock_count_en  <= timer_control_r[`GTU_CTL_CLK_RUN]
                               && !(timer_control_r[`GTU_CTL_A_FREEZE] && debug_halt);
            chan_a_edge_select <=
                gtu_edge_t'(timer_control_r[`GTU_CTL_A_EDGE_LO +: 2]);
            chan_b_edge_select <=
                gtu_edge_t'(timer_control_r[`GTU_CTL_B_EDGE_LO +: 2]);
            unit_mode          <= decode_mode(global_configuration_r);
        end
    end

    // PWM polarity, converter triggers and the interrupt line, each registered.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            chan_a_pwm_out <= 1'b0;
            chan_b_pwm_out <= 1'b0;
            adc_trig_a     <= 1'b0;
            adc_trig_b     <= 1'b0;
            timer_irq      <= 1'b0;
        end
        else
        begin
            chan_a_pwm_out <= a_pwm_raw ^ timer_control_r[`GTU_CTL_A_INV];
            chan_b_pwm_out <= b_pwm_raw ^ timer_control_r[`GTU_CTL_B_INV];
            adc_trig_a     <= a_trig_raw & timer_control_r[`GTU_CTL_A_TRIG];
            adc_trig_b     <= b_trig_raw & timer_control_r[`GTU_CTL_B_TRIG];
            timer_irq      <= |(raw_interrupt_status_r & interrupt_mask_r);
        end
    end

endmodule

// File: gtu_ctrl_assertions.sv
// Concurrent checks on the ports of the timer control block.
`timescale 1ns/1ns
module gtu_ctrl_assertions
(
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_rvalid,
    input wire logic               a_timeout_evt,
    input wire logic               a_match_evt,
    input wire logic               a_capture_evt,
    input wire logic               clock_evt,
    input wire logic               b_timeout_evt,
    input wire logic               b_match_evt,
    input wire logic               b_capture_evt,
    input wire logic               a_trig_raw,
    input wire logic               b_trig_raw,
    input wire logic               debug_halt,
    input wire logic               chan_a_count_en,
    input wire gtu_pkg::gtu_edge_t chan_a_edge_select,
    input wire logic               adc_trig_a,
    input wire logic               adc_trig_b,
    input wire logic               timer_irq
);
    import gtu_pkg::*;
    // ==========================================================================
    // Any event pulse; a rising interrupt must trace back to one or to a write.
    logic evt_any;
    assign evt_any = a_timeout_evt | a_match_evt | a_capture_evt | clock_evt
                   | b_timeout_evt | b_match_evt | b_capture_evt;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================================
    // Steering outputs move only for a cause one or two cycles back; bus answers come on time.
    chk_trig_a_gate: assert property (adc_trig_a |-> $past(a_trig_raw))
        else $error("trigger a without raw trigger");
    chk_trig_b_gate: assert property (adc_trig_b |-> $past(b_trig_raw))
        else $error("trigger b without raw trigger");
    chk_irq_cause: assert property ($rose(timer_irq) |->
        $past(evt_any, 2) || $past(s_axi_bvalid))
        else $error("interrupt rose without event or write");
    chk_run_a_start: assert property ($rose(chan_a_count_en) |->
        $past(s_axi_bvalid) || ($past(debug_halt, 2) && !$past(debug_halt)))
        else $error("channel a started without cause");
    chk_freeze_a_halt: assert property ($fell(chan_a_count_en) |->
        $past(s_axi_bvalid) || ($past(debug_halt) && !$past(debug_halt, 2)))
        else $error("channel a stopped without cause");
    chk_edge_a_write: assert property ($changed(chan_a_edge_select) |->
        $past(s_axi_bvalid))
        else $error("edge select a changed without write");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid)
        else $error("read answer late");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    // Main scenarios reached.
    cov_irq: cover property ($rose(timer_irq));
    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_freeze: cover property ($fell(chan_a_count_en) && debug_halt);
endmodule

bind gtu_ctrl gtu_ctrl_assertions u_chk
(
    .aclk (aclk), .aresetn (aresetn),
    .s_axi_awvalid (s_axi_awvalid), .s_axi_awready (s_axi_awready),
    .s_axi_wvalid (s_axi_wvalid), .s_axi_wready (s_axi_wready),
    .s_axi_bvalid (s_axi_bvalid), .s_axi_bready (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid), .s_axi_arready (s_axi_arready),
    .s_axi_rvalid (s_axi_rvalid),
    .a_timeout_evt (a_timeout_evt), .a_match_evt (a_match_evt),
    .a_capture_evt (a_capture_evt), .clock_evt (clock_evt),
    .b_timeout_evt (b_timeout_evt), .b_match_evt (b_match_evt),
    .b_capture_evt (b_capture_evt),
    .a_trig_raw (a_trig_raw), .b_trig_raw (b_trig_raw), .debug_halt (debug_halt),
    .chan_a_count_en (chan_a_count_en), .chan_a_edge_select (chan_a_edge_select),
    .adc_trig_a (adc_trig_a), .adc_trig_b (adc_trig_b), .timer_irq (timer_irq)
);

// File: timer_control_and_irq_status_test.sv
// Self-checking bench for the timer control and interrupt status block.
`timescale 1ns/1ns
`include "gtu_defines.svh"
module timer_control_and_irq_status_test;
    import gtu_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, ex;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, a_timeout_evt, a_match_evt, a_capture_evt;
    logic        clock_evt, b_timeout_evt, b_match_evt, b_capture_evt;
    logic        a_pwm_raw, b_pwm_raw, a_trig_raw, b_trig_raw, debug_halt, on;
    logic        chan_a_count_en, chan_b_count_en, clock_count_en, timer_irq;
    gtu_edge_t   chan_a_edge_select, chan_b_edge_select;
    gtu_mode_t   unit_mode;
    logic        chan_a_pwm_out, chan_b_pwm_out, adc_trig_a, adc_trig_b;
    logic [6:0]  ev;
    int          n_mismatch, total_checks;
    int          pos [7] = '{0, 1, 2, 3, 8, 9, 10};
    // Event vector in raw bit order, lowest position first.
    assign {b_capture_evt, b_match_evt, b_timeout_evt, clock_evt} = ev[6:3];
    assign {a_capture_evt, a_match_evt, a_timeout_evt} = ev[2:0];
    gtu_ctrl DUT (.*);
    // ==========================================================================
    // Clock, 20 ns period.
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // ==========================================================================
    // Compares and bus tasks.
    task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    // Response channels keep their ready high, so only the requests move.
    // Waits have no limit of their own; a missing answer is left to the watchdog.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        ck("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        ck("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        ck("rdata", e, s_axi_rdata);
    endtask
    // Steering outputs lag the register by one clock; look once they land.
    task automatic settle();
        repeat (2) @(posedge aclk);
        #1;
    endtask
    task automatic pulse(input int i);
        ev <= 7'h1 << i;
        @(posedge aclk);
        ev <= 7'h0;
        settle();
    endtask
    // ==========================================================================
    // Scenarios.
    task automatic t_reset();
        rd(`GTU_CTL_OFS, `GTU_CTL_RESET, 2'h0);
        rd(`GTU_IMR_OFS, `GTU_IMR_RESET, 2'h0);
        rd(`GTU_RIS_OFS, `GTU_RIS_RESET, 2'h0);
        rd(12'h0fc, 32'h0, 2'h2);
        $display("test reset done");
    endtask
    task automatic t_ctl();
        for (int k = 0; k < 2; k++)
        begin
            on = (k == 0);
            a_pwm_raw <= ~on;
            b_pwm_raw <= ~on;
            // Every defined control bit, reserved positions 7 and 12 left alone.
            wr(`GTU_CTL_OFS, on ? 32'h00006f7f : 32'h0, 2'h0);
            rd(`GTU_CTL_OFS, on ? 32'h00006f7f : 32'h0, 2'h0);
            settle();
            ck("a run", on, chan_a_count_en);
            ck("b run", on, chan_b_count_en);
            ck("clock run", on, clock_count_en);
            ck("a pwm", 1'b1, chan_a_pwm_out);
            ck("b pwm", 1'b1, chan_b_pwm_out);
            ck("a trig", on, adc_trig_a);
            ck("b trig", on, adc_trig_b);
        end
        for (int e = 0; e < 4; e++)
        begin
            wr(`GTU_CTL_OFS, (e << 10) | (e << 2), 2'h0);
            settle();
            ck("a edge", e, {30'h0, chan_a_edge_select});
            ck("b edge", e, {30'h0, chan_b_edge_select});
        end
        $display("test control done");
    endtask
    task automatic t_freeze();
        wr(`GTU_CTL_OFS, 32'h00000113, 2'h0);
        debug_halt <= 1'b1;
        settle();
        ck("a run halted", 1'b0, chan_a_count_en);
        ck("clock halted", 1'b0, clock_count_en);
        ck("b run no freeze", 1'b1, chan_b_count_en);
        wr(`GTU_CTL_OFS, 32'h00000313, 2'h0);
        settle();
        ck("b run halted", 1'b0, chan_b_count_en);
        debug_halt <= 1'b0;
        settle();
        ck("a run resumed", 1'b1, chan_a_count_en);
        ck("b run resumed", 1'b1, chan_b_count_en);
        $display("test freeze done");
    endtask
    task automatic t_irq();
        ex = 32'h0;
        for (int i = 0; i < 7; i++)
        begin
            pulse(i);
            ex[pos[i]] = 1'b1;
            rd(`GTU_RIS_OFS, ex, 2'h0);
            ck("irq masked", 1'b0, timer_irq);
        end
        rd(`GTU_MIS_OFS, 32'h0, 2'h0);
        wr(`GTU_RIS_OFS, 32'h0, 2'h2);
        rd(`GTU_RIS_OFS, ex, 2'h0);
        wr(`GTU_IMR_OFS, 32'h0000070f, 2'h0);
        rd(`GTU_IMR_OFS, 32'h0000070f, 2'h0);
        settle();
        ck("irq on", 1'b1, timer_irq);
        rd(`GTU_MIS_OFS, 32'h0000070f, 2'h0);
        wr(`GTU_IMR_OFS, 32'h00000400, 2'h0);
        for (int i = 0; i < 7; i++)
        begin
            wr(`GTU_ICR_OFS, 32'h1 << pos[i], 2'h0);
            ex[pos[i]] = 1'b0;
            rd(`GTU_RIS_OFS, ex, 2'h0);
            rd(`GTU_MIS_OFS, ex & 32'h400, 2'h0);
            settle();
            ck("irq level", ex[10], timer_irq);
        end
        $display("test interrupt done");
    endtask
    task automatic t_cfg();
        logic [2:0] c [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
        gtu_mode_t  m [5] = '{GTU_MODE_T32, GTU_MODE_RTC, GTU_MODE_BAD,
                              GTU_MODE_T16, GTU_MODE_T16};
        for (int i = 0; i < 5; i++)
        begin
            wr(`GTU_CFG_OFS, {29'h0, c[i]}, 2'h0);
            settle();
            ck("mode", {30'h0, m[i]}, {30'h0, unit_mode});
        end
        $display("test config done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================================================
    // Watchdog; the whole run needs a few hundred cycles.
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        end_of_test();
    end
    // Main sequence; ready lines of both response channels stay high throughout.
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ev} = '0;
        {a_pwm_raw, b_pwm_raw, debug_halt, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {a_trig_raw, b_trig_raw, s_axi_bready, s_axi_rready, s_axi_wstrb} = '1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_ctl();
        t_freeze();
        t_irq();
        t_cfg();
        end_of_test();
    end
endmodule
